// file: pwmch_pkg.sv
package pwmch_pkg;
   // ==========================================
   // Register map (byte addresses)
   localparam logic [3:0] PWMCH_OFF_CONTROL = 4'h0;
   localparam logic [3:0] PWMCH_OFF_DUTY_HIGH = 4'h4;
   localparam logic [3:0] PWMCH_OFF_DUTY_LOW = 4'h8;

   // ==========================================
   // Field positions
   localparam int PWMCH_BIT_CHANNEL_ON = 7;
   localparam int PWMCH_BIT_READBACK = 5;
   localparam int PWMCH_BIT_POLARITY = 4;
   localparam int PWMCH_DUTY_LOW_MSB = 7;
   localparam int PWMCH_DUTY_LOW_LSB = 6;

   // ==========================================
   // Reset values
   localparam logic [7:0] PWMCH_RST_CONTROL = 8'h00;
   localparam logic [7:0] PWMCH_RST_DUTY_HIGH = 8'h00;
   localparam logic [1:0] PWMCH_RST_DUTY_LOW = 2'h0;
   localparam logic [9:0] PWMCH_RST_DUTY = 10'h000;

   // ==========================================
   // Bus answers
   localparam logic [1:0] PWMCH_RESP_OKAY = 2'h0;
   localparam logic [1:0] PWMCH_RESP_SLVERR = 2'h2;
   localparam logic [31:0] PWMCH_RDATA_NONE = 32'h0000_0000;
endpackage

// file: pwmch_core.sv
`timescale 1ns/100ps
module pwmch_core
   import pwmch_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic channel_on,
   input wire logic output_polarity,
   input wire logic [9:0] duty_written,
   input wire logic [7:0] period_register,
   input wire logic [7:0] period_timer_count,
   input wire logic [1:0] timer_phase,
   input wire logic timer_wrap,
   output logic pwm_signal
);
   // ==========================================
   // Double-buffered duty and raw output state
   logic [9:0] duty_buf;
   logic [9:0] next_duty_buf;
   logic raw_active;
   logic next_raw_active;
   logic [9:0] time_base;
   logic [10:0] period_span;
   logic duty_in_range;

   assign time_base = {period_timer_count, timer_phase};
   assign period_span = {1'b0, period_register, 2'b00} + 11'h004;
   // A duty at or past the full period never matches, giving 100 %
   assign duty_in_range = ({1'b0, duty_buf} < period_span);

   always_comb begin
      next_duty_buf = duty_buf;
      next_raw_active = raw_active;
      if (timer_wrap) begin
         // Buffers load only at the period match so a duty change never shows mid-period
         next_duty_buf = duty_written;
         // A zero duty keeps the output inactive across the whole period
         next_raw_active = (duty_written != PWMCH_RST_DUTY);
      end else if (raw_active && duty_in_range && (time_base == duty_buf)) begin
         next_raw_active = 1'b0;
      end
      if (!channel_on) begin
         next_raw_active = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         duty_buf <= PWMCH_RST_DUTY;
         raw_active <= 1'b0;
         pwm_signal <= 1'b0;
      end else begin
         duty_buf <= next_duty_buf;
         raw_active <= next_raw_active;
         // Output goes to peripherals regardless of any pin driver state
         pwm_signal <= channel_on & (next_raw_active ^ output_polarity);
      end
   end
endmodule

// file: pwmch_top.sv
`timescale 1ns/100ps
// What this block does
// - PWM signal reaches internal peripherals even with pin drivers disabled.
// - Control bit 7 enables the channel when one, disables when zero.
// - Read-only control bit 5 returns the present channel output level.
// - Control bit 4 set makes output active low, clear active high.
// - Duty high register holds the eight most significant duty bits.
// - Duty low bits 7:6 hold two least significant bits; 5:0 read zero.
// - Control bit 6 and bits 3:0 always read zero.
// - Output sets when timer clears unless duty is zero, clears when time base equals buffered duty.
// - Duty at or above the period never clears the output: 100 percent.
// - Duty writes are double buffered, loading only at the period match.
// - Time base joins the 8-bit timer with two prescaled clock bits.
module pwmch_top
   import pwmch_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] period_register,
   input wire logic [7:0] period_timer_count,
   input wire logic [1:0] timer_phase,
   input wire logic timer_wrap,
   output logic pwm_signal
);
   // ==========================================
   // Register state
   logic channel_on;
   logic next_channel_on;
   logic output_polarity;
   logic next_output_polarity;
   logic [7:0] pwm_duty_high;
   logic [7:0] next_pwm_duty_high;
   logic [1:0] pwm_duty_low;
   logic [1:0] next_pwm_duty_low;
   logic [7:0] control_view;
   logic [7:0] duty_low_view;

   // ==========================================
   // Write channel state
   logic aw_held;
   logic next_aw_held;
   logic [3:0] aw_addr;
   logic [3:0] next_aw_addr;
   logic w_held;
   logic next_w_held;
   logic [7:0] w_byte;
   logic [7:0] next_w_byte;
   logic w_lane;
   logic next_w_lane;
   logic bvalid;
   logic next_bvalid;
   logic [1:0] bresp;
   logic [1:0] next_bresp;
   logic do_write;

   // ==========================================
   // Read channel state
   logic rvalid;
   logic next_rvalid;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic [1:0] rresp;
   logic [1:0] next_rresp;

   // ==========================================
   // Channel core
   pwmch_core i_pwmch_core (
      .aclk(aclk),
      .aresetn(aresetn),
      .channel_on(channel_on),
      .output_polarity(output_polarity),
      .duty_written({pwm_duty_high, pwm_duty_low}),
      .period_register(period_register),
      .period_timer_count(period_timer_count),
      .timer_phase(timer_phase),
      .timer_wrap(timer_wrap),
      .pwm_signal(pwm_signal)
   );

   // ==========================================
   // Read views
   always_comb begin
      control_view = 8'h00;
      control_view[PWMCH_BIT_CHANNEL_ON] = channel_on;
      control_view[PWMCH_BIT_READBACK] = pwm_signal;
      control_view[PWMCH_BIT_POLARITY] = output_polarity;
      duty_low_view = 8'h00;
      duty_low_view[PWMCH_DUTY_LOW_MSB:PWMCH_DUTY_LOW_LSB] = pwm_duty_low;
   end

   // ==========================================
   // Write path: address and data taken in either order
   assign s_axi_awready = !aw_held && !bvalid;
   assign s_axi_wready = !w_held && !bvalid;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign do_write = aw_held && w_held && !bvalid;

   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_byte = w_byte;
      next_w_lane = w_lane;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_channel_on = channel_on;
      next_output_polarity = output_polarity;
      next_pwm_duty_high = pwm_duty_high;
      next_pwm_duty_low = pwm_duty_low;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_byte = s_axi_wdata[7:0];
         next_w_lane = s_axi_wstrb[0];
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = PWMCH_RESP_OKAY;
         // Only byte lane 0 carries data; other lanes are ignored
         unique case (aw_addr)
            PWMCH_OFF_CONTROL: begin
               if (w_lane) begin
                  next_channel_on = w_byte[PWMCH_BIT_CHANNEL_ON];
                  next_output_polarity = w_byte[PWMCH_BIT_POLARITY];
               end
            end
            PWMCH_OFF_DUTY_HIGH: begin
               if (w_lane) begin
                  next_pwm_duty_high = w_byte;
               end
            end
            PWMCH_OFF_DUTY_LOW: begin
               if (w_lane) begin
                  next_pwm_duty_low = w_byte[PWMCH_DUTY_LOW_MSB:PWMCH_DUTY_LOW_LSB];
               end
            end
            default: begin
               next_bresp = PWMCH_RESP_SLVERR;
            end
         endcase
      end else if (bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 4'h0;
         w_held <= 1'b0;
         w_byte <= 8'h00;
         w_lane <= 1'b0;
         bvalid <= 1'b0;
         bresp <= PWMCH_RESP_OKAY;
         channel_on <= PWMCH_RST_CONTROL[PWMCH_BIT_CHANNEL_ON];
         output_polarity <= PWMCH_RST_CONTROL[PWMCH_BIT_POLARITY];
         pwm_duty_high <= PWMCH_RST_DUTY_HIGH;
         pwm_duty_low <= PWMCH_RST_DUTY_LOW;
      end else begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_byte <= next_w_byte;
         w_lane <= next_w_lane;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         channel_on <= next_channel_on;
         output_polarity <= next_output_polarity;
         pwm_duty_high <= next_pwm_duty_high;
         pwm_duty_low <= next_pwm_duty_low;
      end
   end

   // ==========================================
   // Read path: one outstanding read, data registered
   assign s_axi_arready = !rvalid;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rdata = rdata;
   assign s_axi_rresp = rresp;

   always_comb begin
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (s_axi_arvalid && !rvalid) begin
         next_rvalid = 1'b1;
         next_rresp = PWMCH_RESP_OKAY;
         // Readback samples the output level at the moment of the read
         unique case (s_axi_araddr)
            PWMCH_OFF_CONTROL: begin
               next_rdata = {24'h000000, control_view};
            end
            PWMCH_OFF_DUTY_HIGH: begin
               next_rdata = {24'h000000, pwm_duty_high};
            end
            PWMCH_OFF_DUTY_LOW: begin
               next_rdata = {24'h000000, duty_low_view};
            end
            default: begin
               next_rdata = PWMCH_RDATA_NONE;
               next_rresp = PWMCH_RESP_SLVERR;
            end
         endcase
      end else if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= PWMCH_RDATA_NONE;
         rresp <= PWMCH_RESP_OKAY;
      end else begin
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end
endmodule

// file: pwmch_timer_model.sv
`timescale 1ns/100ps
// ========
// Shared period timer at prescale 1:1, clears after matching period
module pwmch_timer_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   input wire logic [7:0] period,
   output logic [7:0] count,
   output logic [1:0] phase,
   output logic wrap
);
   logic [7:0] next_count;
   logic [1:0] next_phase;
   logic next_wrap;
   always_comb begin
      next_phase = phase + 2'h1;
      next_wrap = run && (phase == 2'h3) && (count >= period);
      next_count = count;
      // Compare with >= so a period lowered mid-count still clears
      if (phase == 2'h3) begin
         next_count = next_wrap ? 8'h00 : count + 8'h01;
      end
      if (!run) begin
         next_phase = phase;
      end
   end
   always_ff @(posedge aclk) begin
      count <= aresetn ? next_count : 8'h00;
      phase <= aresetn ? next_phase : 2'h0;
      wrap <= aresetn ? next_wrap : 1'b0;
   end
endmodule

// file: pwmch_monitor.sv
`timescale 1ns/100ps
module pwmch_monitor
   import pwmch_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic pwm_signal
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic aw_take;
   logic ar_take;
   assign aw_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign ar_take = s_axi_arvalid && s_axi_arready;
   // ========
   // Register reads
   readback_level_a: assert property (
      ar_take && s_axi_araddr == 4'h0 |=> s_axi_rdata[5] == $past(pwm_signal)) else $error("readback bit wrong");
   control_zero_a: assert property (
      ar_take && s_axi_araddr == 4'h0 |=> {s_axi_rdata[31:8], s_axi_rdata[6], s_axi_rdata[3:0]} == 29'h0)
      else $error("control spare bits set");
   duty_low_zero_a: assert property (
      ar_take && s_axi_araddr == 4'h8 |=> {s_axi_rdata[31:8], s_axi_rdata[5:0]} == 30'h0)
      else $error("duty low spare bits set");
   duty_high_a: assert property (
      ar_take && s_axi_araddr == 4'h4 |=> s_axi_rdata[31:8] == 24'h0) else $error("duty high upper bits set");
   unmapped_read_a: assert property (ar_take && s_axi_araddr == 4'hc |=> s_axi_rresp == PWMCH_RESP_SLVERR
      && s_axi_rdata == 32'h0) else $error("unmapped read answer wrong");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   // ========
   // Writes and output
   write_answer_a: assert property (aw_take |=> ##1 s_axi_bvalid) else $error("write answer late");
   busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
   channel_off_a: assert property (
      aw_take && s_axi_awaddr == 4'h0 && s_axi_wstrb[0] && !s_axi_wdata[7] |=> ##2 !pwm_signal)
      else $error("disabled channel still drives");
   cover property (ar_take && s_axi_araddr == 4'hc);
   cover property (ar_take && s_axi_araddr == 4'h0 ##1 s_axi_rdata[5]);
   cover property ($fell(pwm_signal));
endmodule
bind pwmch_top pwmch_monitor i_pwmch_monitor (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_signal);

// file: test_pwm_channel_setup_and_regs.sv
`timescale 1ns/100ps
module test_pwm_channel_setup_and_regs
   import pwmch_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic run = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp, timer_phase;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer_wrap, pwm_signal;
   logic [7:0] period_register = 8'h08, period_timer_count;
   int err_count = 0;
   int cmp_count = 0;
   pwmch_top i_pwmch_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .period_register, .period_timer_count, .timer_phase, .timer_wrap, .pwm_signal);
   pwmch_timer_model i_pwmch_timer_model (.aclk, .aresetn, .run, .period(period_register),
      .count(period_timer_count), .phase(timer_phase), .wrap(timer_wrap));
   initial begin
      forever #5 aclk = ~aclk;
   end
   // ========
   // Checking and bus tasks
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic bound(input logic ok);
      if (!ok) begin
         chk("timeout", 0, 1);
         results();
      end
   endtask
   // Ready and answer are sampled mid-cycle, where they are settled
   task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
      logic pa, pw, pb, ka, kw;
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      {pa, pw, pb} = 3'b111;
      for (n = 0; pb && n < 64; n++) begin
         @(negedge aclk);
         ka = s_axi_awready;
         kw = s_axi_wready;
         pb = !s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         pa = pa && !ka;
         pw = pw && !kw;
         {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {pa, pw, pb};
      end
      bound(!pb);
   endtask
   // A taker that starts not ready at random leaves the read answer waiting, so its hold is exercised
   task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ka, kr, kd;
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'($urandom);
      kd = 1'b0;
      for (n = 0; !kd && n < 64; n++) begin
         @(negedge aclk);
         ka = s_axi_arready;
         kr = s_axi_rvalid;
         kd = s_axi_rvalid && s_axi_rready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ka) s_axi_arvalid <= 1'b0;
         if (kd) begin
            s_axi_rready <= 1'b0;
         end else if (kr) begin
            s_axi_rready <= 1'b1;
         end
      end
      bound(kd);
   endtask
   task automatic wait_wrap();
      int n;
      n = 0;
      do begin
         @(negedge aclk);
         n++;
      end while (timer_wrap !== 1'b1 && n < 2000);
      bound(timer_wrap === 1'b1);
   endtask
   // One full period from a buffer load; a new duty high lands mid-period
   task automatic measure(input logic [7:0] mid, output int hi);
      logic [1:0] r;
      hi = 0;
      wait_wrap();
      fork
         for (int k = 0; k < 4 * (period_register + 1); k++) begin
            @(negedge aclk);
            hi += (pwm_signal === 1'b1);
         end
         wr(PWMCH_OFF_DUTY_HIGH, mid, r);
      join
   endtask
   function automatic int exp_high(input logic [9:0] d, input logic [7:0] p, input logic pol, input logic on);
      int full, act;
      full = 4 * (p + 1);
      act = (d >= full) ? full : d;
      return on ? (pol ? full - act : act) : 0;
   endfunction
   // ========
   // Main sequence
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [9:0] duty;
      logic [7:0] p;
      logic pol, on;
      int hi;
      void'($urandom(32'h405d2dfd));
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         rd(4'(4 * i), d, r);
         chk("reset value", d, 32'h0);
      end
      wr(4'hc, 8'hff, r);
      chk("unmapped bresp", r, PWMCH_RESP_SLVERR);
      rd(4'hc, d, r);
      chk("unmapped rresp", r, PWMCH_RESP_SLVERR);
      chk("unmapped read", d, PWMCH_RDATA_NONE);
      for (int i = 0; i < 40; i++) begin
         p = 8'(8 + $urandom_range(23));
         duty = (i % 4 == 0) ? 10'h0 : (i % 4 == 1) ? 10'(4 * (p + 1)) : (i % 4 == 2) ? 10'(4 * p + 3) : 10'($urandom);
         on = (i % 5 != 4);
         pol = 1'($urandom);
         // Pins stay inputs: the output only feeds internal consumers
         wr(PWMCH_OFF_CONTROL, 8'h00, r);
         period_register <= p;
         wr(PWMCH_OFF_DUTY_HIGH, duty[9:2], r);
         wr(PWMCH_OFF_DUTY_LOW, {duty[1:0], 6'h3f}, r);
         rd(PWMCH_OFF_DUTY_HIGH, d, r);
         chk("duty high", d, {24'h0, duty[9:2]});
         rd(PWMCH_OFF_DUTY_LOW, d, r);
         chk("duty low", d, {24'h0, duty[1:0], 6'h0});
         run <= 1'b1;
         if (i % 3 != 0) wait_wrap();
         wr(PWMCH_OFF_CONTROL, {on, 2'b11, pol, 4'hf}, r);
         chk("control bresp", r, PWMCH_RESP_OKAY);
         rd(PWMCH_OFF_CONTROL, d, r);
         chk("control", d & 32'hffffffdf, {24'h0, on, 2'h0, pol, 4'h0});
         measure((duty == 0) ? 8'h00 : 8'($urandom), hi);
         chk("high cycles", hi, exp_high(duty, p, pol, on));
         if (duty == 0) begin
            rd(PWMCH_OFF_CONTROL, d, r);
            chk("level readback", d[5], on & pol);
         end
         $display("test %0d done", i);
      end
      results();
   end
endmodule
